/* logic/dual_timer_counter.sv */
// two timer/counters with an axi4-lite register slave
//
// Implementation choices: the address map and the AXI4-Lite register port.
module dual_timer_counter
  import dual_timer_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // external pins
  input wire logic count_input_a,
  input wire logic count_input_b,
  input wire logic gate_input_a,
  input wire logic gate_input_b,
  // axi4-lite write
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // overflow flags
  output logic ovf0,
  output logic ovf1
);
  tmode_t mode0_r, mode1_r;
  tcount_t cnt0_r, cnt1_r;
  logic [4:0] pre0_r, pre1_r;
  logic [2:0] mc_r;
  logic [1:0] run_r;
  logic [3:0] aw_r;
  logic aw_ok_r, w_ok_r;
  logic [31:0] w_r;
  logic [3:0] ws_r;
  logic cin0_r, cin1_r, cprev0_r, cprev1_r;
  logic mc_tick;
  logic edge0, edge1, inc0, inc1, inc0h;
  logic wr_go;
  logic wr_mode, wr_ctrl, wr_cnt0, wr_cnt1;

  function automatic logic [7:0] wbyte(input logic [7:0] old, input logic [7:0] nw, input logic en);
    wbyte = en ? nw : old;
  endfunction

  ////////////////////////////////////////////////////////////////
  // machine cycle: six clocks stand for six oscillator periods
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mc_r <= 3'h0;
    end else begin
      mc_r <= (mc_r == mc_last) ? 3'h0 : mc_r + 3'h1;
    end
  end
  assign mc_tick = (mc_r == mc_last);  // see (R04)

  // pins sampled once per machine cycle; an edge needs two samples
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cin0_r <= 1'b1;
      cin1_r <= 1'b1;
      cprev0_r <= 1'b1;
      cprev1_r <= 1'b1;
    end else if (mc_tick) begin
      cin0_r <= count_input_a;  // see (R06)
      cin1_r <= count_input_b;
      cprev0_r <= cin0_r;
      cprev1_r <= cin1_r;
    end
  end
  assign edge0 = cprev0_r & ~cin0_r;  // see (R05)
  assign edge1 = cprev1_r & ~cin1_r;

  // count enables: source, run bit and optional gate
  always_comb begin
    inc0 = mc_tick & run_r[0] & (mode0_r.cnt_sel ? edge0 : 1'b1)  // see (R04) (R05)
           & (~mode0_r.gate_en | gate_input_a);  // see (R07)
    inc1 = mc_tick & run_r[1] & (mode1_r.cnt_sel ? edge1 : 1'b1)
           & (~mode1_r.gate_en | gate_input_b)  // see (R07)
           & (mode0_r.mode != mode_split);  // see (R03)
    // split high half of timer 0 is a pure timer on timer 1's run bit
    inc0h = mc_tick & run_r[1] & (mode0_r.mode == mode_split);  // see (R03)
  end

  ////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order
  assign wr_go = aw_ok_r & w_ok_r & ~bvalid;
  assign wr_mode = wr_go & (aw_r == mode_addr);
  assign wr_ctrl = wr_go & (aw_r == ctrl_addr);
  assign wr_cnt0 = wr_go & (aw_r == cnt0_addr);
  assign wr_cnt1 = wr_go & (aw_r == cnt1_addr);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      aw_r <= 4'h0;
      w_r <= 32'h0;
      ws_r <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= resp_okay;
    end else begin
      awready <= ~aw_ok_r & ~awready & awvalid;
      wready <= ~w_ok_r & ~wready & wvalid;
      if (awvalid & awready) begin
        aw_ok_r <= 1'b1;
        aw_r <= {awaddr[3:2], 2'h0};
      end
      if (wvalid & wready) begin
        w_ok_r <= 1'b1;
        w_r <= wdata;
        ws_r <= wstrb;
      end
      if (wr_go) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= resp_okay;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // mode register: timer 0 in bits 3:0, timer 1 in bits 7:4
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode0_r <= '0;
      mode1_r <= '0;
    end else if (wr_mode & ws_r[0]) begin
      mode0_r <= w_r[3:0];  // see (R01)
      mode1_r <= w_r[7:4];
    end
  end

  // run bits, software sets and clears
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 2'h0;
    end else if (wr_ctrl & ws_r[0]) begin
      run_r <= w_r[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // timer 0 counting; a write takes priority over a count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt0_r <= '0;
      pre0_r <= 5'h0;
      ovf0 <= 1'b0;
    end else begin
      if (wr_cnt0) begin
        cnt0_r.low <= wbyte(cnt0_r.low, w_r[7:0], ws_r[0]);
        cnt0_r.high <= wbyte(cnt0_r.high, w_r[15:8], ws_r[1]);
      end else begin
        if (inc0) begin
          case (mode0_r.mode)
            mode_presc: begin
              pre0_r <= pre0_r + 5'h1;  // see (R02)
              if (pre0_r == presc_last) cnt0_r.high <= cnt0_r.high + 8'h1;
            end
            mode_wide: cnt0_r <= cnt0_r + 16'h1;  // see (R08)
            mode_reload: cnt0_r.low <= (cnt0_r.low == byte_ones) ? cnt0_r.high : cnt0_r.low + 8'h1;
            default: cnt0_r.low <= cnt0_r.low + 8'h1;  // see (R03)
          endcase
        end
        if (inc0h) cnt0_r.high <= cnt0_r.high + 8'h1;  // see (R03)
      end
      // set beats the clear written in the same cycle; a count lost to a write sets no flag
      if (wr_ctrl & ws_r[0] & w_r[4]) ovf0 <= 1'b0;
      if (inc0 && !wr_cnt0 && (((mode0_r.mode == mode_wide) && (cnt0_r == 16'hffff)) ||
          ((mode0_r.mode == mode_presc) && (pre0_r == presc_last) && (cnt0_r.high == byte_ones)) ||
          ((mode0_r.mode[1]) && (cnt0_r.low == byte_ones))))
        ovf0 <= 1'b1;  // see (R08)
    end
  end

  // timer 1 counting; in split it holds, its flag is driven by timer 0 high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt1_r <= '0;
      pre1_r <= 5'h0;
      ovf1 <= 1'b0;
    end else begin
      if (wr_cnt1) begin
        cnt1_r.low <= wbyte(cnt1_r.low, w_r[7:0], ws_r[0]);
        cnt1_r.high <= wbyte(cnt1_r.high, w_r[15:8], ws_r[1]);
      end else if (inc1) begin
        case (mode1_r.mode)
          mode_presc: begin
            pre1_r <= pre1_r + 5'h1;  // see (R02)
            if (pre1_r == presc_last) cnt1_r.high <= cnt1_r.high + 8'h1;
          end
          mode_wide: cnt1_r <= cnt1_r + 16'h1;  // see (R08)
          mode_reload: cnt1_r.low <= (cnt1_r.low == byte_ones) ? cnt1_r.high : cnt1_r.low + 8'h1;
          default: cnt1_r <= cnt1_r;  // mode 3 on timer 1 holds its count
        endcase
      end
      if (wr_ctrl & ws_r[0] & w_r[5]) ovf1 <= 1'b0;
      if ((inc1 && !wr_cnt1 && (((mode1_r.mode == mode_wide) && (cnt1_r == 16'hffff)) ||
          ((mode1_r.mode == mode_presc) && (pre1_r == presc_last) && (cnt1_r.high == byte_ones)) ||
          ((mode1_r.mode == mode_reload) && (cnt1_r.low == byte_ones)))) ||
          (inc0h && !wr_cnt0 && (cnt0_r.high == byte_ones)))
        ovf1 <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // axi4-lite read path
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= resp_okay;
    end else begin
      arready <= ~arready & ~rvalid & arvalid;
      if (arvalid & arready) begin
        rvalid <= 1'b1;
        rresp <= resp_okay;
        if ({araddr[3:2], 2'h0} == mode_addr) rdata <= {24'h0, mode1_r, mode0_r};
        else if ({araddr[3:2], 2'h0} == ctrl_addr) rdata <= {26'h0, ovf1, ovf0, 2'h0, run_r};
        else if ({araddr[3:2], 2'h0} == cnt0_addr) rdata <= {16'h0, cnt0_r};
        else rdata <= {16'h0, cnt1_r};
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  machine_tick_a: assert property (@(posedge clock) disable iff (!rst_n)
    mc_tick |=> !mc_tick [*5]) else $error("machine tick not every six clocks");  // see (R04)
  split_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (mode0_r.mode == mode_split && !wr_cnt1) |=> $stable(cnt1_r)) else $error("timer 1 moved in split");  // see (R03)
  gate_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (mode0_r.gate_en && !gate_input_a && !wr_cnt0 && !inc0h && mode0_r.mode == mode_wide)
    |=> $stable(cnt0_r)) else $error("gated timer 0 counted");  // see (R07)
  wide_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    (inc0 && !wr_cnt0 && mode0_r.mode == mode_wide) |=> cnt0_r == $past(cnt0_r) + 16'h1)
    else $error("16-bit step wrong");  // see (R08)
  wide_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
    (inc0 && !wr_cnt0 && mode0_r.mode == mode_wide && cnt0_r == 16'hffff) |=> ovf0)
    else $error("wrap flag missing");  // see (R08)
  presc_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    (inc0 && !wr_cnt0 && mode0_r.mode == mode_presc && pre0_r != presc_last) |=> $stable(cnt0_r))
    else $error("prescaler leaked");  // see (R02)
  // judged from the pin itself: high two machine cycles back, low one machine cycle back
  edge_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    (inc0 && mode0_r.cnt_sel) |-> ($past(count_input_a, 12) && !$past(count_input_a, 6)))
    else $error("count without falling edge");  // see (R05)
  reload_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    (inc1 && !wr_cnt1 && mode1_r.mode == mode_reload && cnt1_r.low == byte_ones)
    |=> cnt1_r.low == $past(cnt1_r.high)) else $error("reload missed");  // see (R01)
  edge_space_a: assert property (@(posedge clock) disable iff (!rst_n)
    (inc1 && mode1_r.cnt_sel) |=> !inc1 [*8]) else $error("edges too close");  // see (R06)
endmodule  // dual_timer_counter

/* logic/dual_timer_pkg.sv */
// constants and carriers for the two-channel timer/counter block
// Operation
// (R01) each timer has four modes from a two-bit field: 00 prescaled, 10 reload, 11 split
// (R02) mode 0: 8-bit counter fed through a divide-by-32 prescaler
// (R03) mode 3: timer 0 splits into two 8-bit counters, timer 1 stops
// (R04) timer function counts once per machine cycle, one sixth of oscillator rate
// (R05) counter function counts each falling edge on its external count input
// (R06) edge detection takes two machine cycles; source edges no faster than osc/12
// (R07) each timer may be gated by its external gate input for pulse measurement
// (R08) mode 1 counts 16 bits and sets overflow flag on wrap to zero
package dual_timer_pkg;
  // register byte addresses
  localparam logic [3:0] mode_addr = 4'h0;  // timer_mode_register
  localparam logic [3:0] ctrl_addr = 4'h4;  // run bits and overflow flags
  localparam logic [3:0] cnt0_addr = 4'h8;  // timer 0 high:low
  localparam logic [3:0] cnt1_addr = 4'hc;  // timer 1 high:low
  // mode field encodings
  localparam logic [1:0] mode_presc = 2'h0;
  localparam logic [1:0] mode_wide = 2'h1;
  localparam logic [1:0] mode_reload = 2'h2;
  localparam logic [1:0] mode_split = 2'h3;
  // timing: one machine cycle is six oscillator periods
  localparam int osc_per_mc = 6;
  localparam logic [2:0] mc_last = 3'(osc_per_mc - 1);
  localparam logic [4:0] presc_last = 5'h1f;  // divide by 32
  localparam logic [7:0] byte_ones = 8'hff;
  // axi responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // per-timer mode nibble: gate, counter select, mode
  typedef struct packed {
    logic gate_en;
    logic cnt_sel;
    logic [1:0] mode;
  } tmode_t;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } tcount_t;
endpackage

/* verif/pin_source.sv */
// far-side model of the external count and gate pins
module pin_source (
  // clock
  input wire logic clock,
  // pins driven into the block
  output logic cnt_a,
  output logic cnt_b,
  output logic gate_a,
  output logic gate_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle high, as pulled-up port pins rest between events
  initial begin
    cnt_a = 1'b1;
    cnt_b = 1'b1;
    gate_a = 1'b1;
    gate_b = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // n falling edges; each level held two machine cycles so no edge is missed
  task automatic pulse(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      if (sel == 0) cnt_a <= 1'b0;
      else cnt_b <= 1'b0;
      repeat (12) @(posedge clock);
      if (sel == 0) cnt_a <= 1'b1;
      else cnt_b <= 1'b1;
      repeat (12) @(posedge clock);
    end
  endtask

  // gate level for pulse-width style counting
  task automatic set_gate(input int sel, input logic lvl);
    @(posedge clock);
    if (sel == 0) gate_a <= lvl;
    else gate_b <= lvl;
  endtask
endmodule // pin_source

/* verif/test_dual_timer_counter.sv */
// self-checking bench for the two-channel timer/counter
module test_dual_timer_counter;
  import dual_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int t; logic [3:0] m; logic [15:0] pre; int e; logic [15:0] ex; logic ov;} row_t;
  logic clock, rst_n, cnt_a, cnt_b, gate_a, gate_b;
  logic [3:0] awaddr, wstrb, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, ovf0, ovf1;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp;
  int fails, samples_checked;
  row_t rows [6];

  dual_timer_counter DUT (.clock(clock), .rst_n(rst_n), .count_input_a(cnt_a), .count_input_b(cnt_b),
    .gate_input_a(gate_a), .gate_input_b(gate_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .ovf0(ovf0), .ovf1(ovf1));
  pin_source pins (.clock(clock), .cnt_a(cnt_a), .cnt_b(cnt_b), .gate_a(gate_a), .gate_b(gate_b));

  ////////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic stop_test();
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic ad, dd;
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (!ad && awready) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (!dd && wready) begin
        wvalid <= 1'b0;
        dd = 1'b1;
      end
      if (bvalid) break;
    end
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, resp_okay});
    if (n == 50) begin
      fails++;
      stop_test();
    end
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rready <= 1'b0;
    check({30'h0, rresp}, {30'h0, resp_okay});
    if (n == 50) begin
      fails++;
      stop_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // rows: timer, mode nibble, preload, falling edges, expected count, expected flag
  initial begin
    rows[0] = '{1, 4'h5, 16'h00ff, 1, 16'h0100, 1'b0};
    rows[1] = '{0, 4'h4, 16'hff00, 32, 16'h0000, 1'b1};
    rows[2] = '{0, 4'h5, 16'hfffe, 3, 16'h0001, 1'b1};
    rows[3] = '{0, 4'h6, 16'h10fe, 3, 16'h1011, 1'b1};
    rows[4] = '{0, 4'h7, 16'h00fe, 2, 16'h0000, 1'b1};
    rows[5] = '{1, 4'h6, 16'h20ff, 2, 16'h2021, 1'b1};
    {awaddr, wstrb, araddr, wdata} = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    fails = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    // every register clears on reset
    for (int a = 0; a < 4; a++) begin
      axi_read(4'(a * 4), v);
      check(v, 32'h0);
    end
    foreach (rows[i]) begin
      axi_write(ctrl_addr, 32'h30);
      axi_write(mode_addr, 32'(rows[i].m) << (4 * rows[i].t));
      axi_write(rows[i].t ? cnt1_addr : cnt0_addr, {16'h0, rows[i].pre});
      axi_write(ctrl_addr, 32'(1 << rows[i].t));
      pins.pulse(rows[i].t, rows[i].e);
      repeat (18) @(posedge clock);
      axi_write(ctrl_addr, 32'h0);
      axi_read(rows[i].t ? cnt1_addr : cnt0_addr, v);
      check(v, {16'h0, rows[i].ex});
      check(rows[i].t ? ovf1 : ovf0, rows[i].ov);
    end
    // mid-run reset drops a standing flag at once
    rst_n <= 1'b0;
    @(posedge clock);
    check(ovf0, 1'b0);
    check(ovf1, 1'b0);
    rst_n <= 1'b1;
    axi_read(ctrl_addr, v);
    check(v, 32'h0);
    // gate low holds a running timer still, gate high lets it count machine cycles
    axi_write(mode_addr, 32'h9);
    pins.set_gate(0, 1'b0);
    axi_write(ctrl_addr, 32'h1);
    repeat (120) @(posedge clock);
    axi_read(cnt0_addr, v);
    check(v, 32'h0);
    pins.set_gate(0, 1'b1);
    repeat (600) @(posedge clock);
    pins.set_gate(0, 1'b0);
    axi_read(cnt0_addr, v);
    check(32'(v >= 98 && v <= 102), 32'h1);
    // split mode: timer 1 frozen, timer 0 high byte runs on the second run bit and wraps into flag 1
    axi_write(ctrl_addr, 32'h0);
    axi_write(mode_addr, 32'h13);
    axi_write(cnt0_addr, 32'hf000);
    axi_write(cnt1_addr, 32'h1234);
    axi_write(ctrl_addr, 32'h2);
    repeat (120) @(posedge clock);
    axi_read(cnt1_addr, v);
    check(v, 32'h1234);
    axi_read(cnt0_addr, v);
    check(32'(v[15:8] >= 3 && v[15:8] <= 7 && v[7:0] == 8'h00), 32'h1);
    check(ovf1, 1'b1);
    stop_test();
  end
endmodule // test_dual_timer_counter
